/* rsq_defs.vh */
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH

// Register offsets (word index on the plain register port)
`define RSQ_ADDR_W 4
`define RSQ_REG_CAUSE 4'h0
`define RSQ_REG_OPTION 4'h1
`define RSQ_REG_IRQ_EN 4'h2
`define RSQ_REG_IRQ_PEND 4'h3
`define RSQ_REG_STATUS 4'h4
`define RSQ_REG_IRQ_VEC 4'h5
`define RSQ_REG_PRESCALE 4'h6

// Reset cause field positions
`define RSQ_CAUSE_POR 7
`define RSQ_CAUSE_PIN 6
`define RSQ_CAUSE_WDOG 5
`define RSQ_CAUSE_OPC 4
`define RSQ_CAUSE_ADR 3
`define RSQ_CAUSE_LV 1
`define RSQ_CAUSE_RST 8'h80

// Option bits
`define RSQ_OPT_STOP_EN 0
`define RSQ_OPT_SHORT_REC 1
`define RSQ_OPT_RST 8'h00

// Counts in reference-clock cycles, then prescaler and watchdog widths and interrupt source count
`define RSQ_PIN_DRIVE_CYC 32
`define RSQ_INTERNAL_RESET_SIGNAL_EXTRA_CYC 32
`define RSQ_POR_CYC 4096
`define RSQ_POR_TAIL_CYC 64
`define RSQ_PIN_MIN_CYC 67
`define RSQ_REC_SHORT_CYC 32
`define RSQ_REC_LONG_CYC 4096
`define RSQ_PRESCALE_W 13
`define RSQ_WDOG_W 8
`define RSQ_NIRQ 8

`endif

/* rsq_reset_sequencer.v */
// Functional notes
// - Internal reset drives reset pin low for 32 reference cycles.
// - Internal reset stays asserted 32 more cycles after pin drive ends.
// - Power-on or low-voltage reset first counts 4096 cycles with pin low.
// - Power-on holds clocks off 4096 cycles, releases CPU 64 cycles later.
// - Power-on sets its cause flag and clears all others.
// - Watchdog overflow makes internal reset and sets watchdog flag.
// - Watchdog reset request is taken asynchronously, so it is synchronised.
// - Write to top vector clears watchdog and prescaler bits 12 to 4.
// - 13-bit prescaler on reference clock falling edge clocks watchdog.
// - Watchdog disabled only by high-voltage detect in monitor or break.
// - Illegal instruction sets bad opcode flag and makes internal reset.
// - With stop disallowed, stop instruction acts as illegal opcode.
// - Only opcode fetch from unmapped address causes address reset.
// - Low-voltage request sets flag, pin low 4096 cycles, CPU 64 later; code keeps pin low 4128 cycles, CPU 32 after.
// - Stop clears prescaler; wake delay 32 if short option else 4096.
// - Pin reset leaves prescaler alone; it runs free after resets.
// - Interrupts latched and arbitrated; latched one holds until serviced.
// - Interrupt entry saves registers and sets mask; return restores.
// - Interrupt begins only at instruction end, mask clear, source enabled.
// - Highest priority pending source is serviced first.
// - Interrupt pending at return is serviced before next program op.
// - Internal reset clears prescaler; each source sets its own flag.
// - Pin flag only if pin held low 67 cycles, not power-on or low-voltage.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "rsq_defs.vh"

module rsq_reset_sequencer (
  input wire sys_clk_i, // System clock, 10 MHz
  input wire rst_b_i, // Async reset, active low
  input wire osc_ref_tick_i, // Falling edge of osc_reference_clock, one cycle
  input wire power_on_pulse_i, // Power-on pulse
  input wire low_voltage_i, // Low-voltage request
  input wire wdog_async_i, // Watchdog reset request, asynchronous
  input wire bad_opcode_i, // CPU decoded illegal instruction
  input wire stop_exec_i, // CPU executes stop instruction
  input wire opcode_fetch_i, // Current access is opcode fetch
  input wire unmapped_i, // Current access address unmapped
  input wire top_vec_wr_i, // Write to top vector address
  input wire monitor_mode_i, // Monitor mode
  input wire break_state_i, // Break state
  input wire hv_rst_pin_i, // High voltage on reset pin
  input wire hv_irq_pin_i, // High voltage on external interrupt pin
  input wire wake_i, // Wake from stop
  input wire rst_pin_in_i, // Reset pin level
  input wire [`RSQ_NIRQ-1:0] irq_req_i, // Interrupt requests
  input wire instr_done_i, // Current instruction completes
  input wire rti_i, // Return from interrupt executed
  input wire [`RSQ_ADDR_W-1:0] reg_addr_i, // Register address
  input wire [7:0] reg_wdata_i, // Register write data
  input wire reg_wr_i, // Register write strobe
  input wire reg_rd_i, // Register read strobe
  output reg [7:0] reg_rdata_o, // Register read data
  output reg rst_pin_out_o, // Reset pin output value
  output reg rst_pin_oe_o, // Reset pin output enable
  output reg internal_reset_o, // Internal reset to modules
  output reg bus_clk_en_o, // Internal bus clocks enabled
  output reg irq_take_o, // Begin interrupt entry, one cycle
  output reg [2:0] irq_vec_o, // Arbitrated vector index
  output reg irq_mask_o, // Interrupt mask bit
  output reg stack_save_o, // Save registers to stack, one cycle
  output reg stack_restore_o // Restore registers from stack, one cycle
);

  localparam ST_RUN = 3'd0;
  localparam ST_LONG = 3'd1;
  localparam ST_DRIVE = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_TAIL = 3'd4;
  localparam ST_STOP = 3'd5;
  localparam ST_WAKE = 3'd6;
  localparam ST_PIN = 3'd7;

  reg [2:0] st_q;
  reg [12:0] cnt_q;
  reg [`RSQ_PRESCALE_W-1:0] pre_q;
  reg [`RSQ_WDOG_W-1:0] wdog_q;
  reg wd_s1_q;
  reg wd_s2_q;
  reg [7:0] cause_q;
  reg [7:0] option_q;
  reg [`RSQ_NIRQ-1:0] irq_en_q;
  reg [`RSQ_NIRQ-1:0] irq_lat_q;
  reg irq_held_q;
  reg [2:0] held_vec_q;
  reg [6:0] pin_cnt_q;
  reg [7:0] new_cause;
  reg int_src;
  reg long_src;
  reg pre_ovf;
  reg [`RSQ_NIRQ-1:0] live;
  wire wdog_disable;

  // Lowest index wins
  function [2:0] prio;
    input [`RSQ_NIRQ-1:0] v;
    integer i;
    begin
      prio = 3'd0;
      for (i = `RSQ_NIRQ - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          prio = i[2:0];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Reset source decode
  // ----------------------------------------
  // HV disable gating
  assign wdog_disable = (monitor_mode_i & (hv_rst_pin_i | hv_irq_pin_i)) |
                        (break_state_i & hv_rst_pin_i);

  always @* begin
    new_cause = 8'h00;
    pre_ovf = osc_ref_tick_i & (&pre_q);
    live = irq_lat_q & irq_en_q;
    if (power_on_pulse_i) begin
      new_cause[`RSQ_CAUSE_POR] = 1'b1;
    end else if (low_voltage_i) begin
      new_cause[`RSQ_CAUSE_LV] = 1'b1;
    end else if (wd_s2_q) begin
      new_cause[`RSQ_CAUSE_WDOG] = 1'b1;
    end else if (bad_opcode_i | (stop_exec_i & ~option_q[`RSQ_OPT_STOP_EN])) begin
      new_cause[`RSQ_CAUSE_OPC] = 1'b1;
    end else if (opcode_fetch_i & unmapped_i) begin
      new_cause[`RSQ_CAUSE_ADR] = 1'b1;
    end
    int_src = |new_cause;
    long_src = power_on_pulse_i | low_voltage_i;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_LONG;
      cnt_q <= 13'h0000;
      cause_q <= `RSQ_CAUSE_RST;
      pin_cnt_q <= 7'h00;
      rst_pin_out_o <= 1'b0;
      rst_pin_oe_o <= 1'b1;
      internal_reset_o <= 1'b1;
      bus_clk_en_o <= 1'b0;
    end else begin
      if (int_src) begin
        cause_q <= new_cause;
        cnt_q <= 13'h0000;
        st_q <= long_src ? ST_LONG : ST_DRIVE;
        rst_pin_oe_o <= 1'b1;
        internal_reset_o <= 1'b1;
        bus_clk_en_o <= ~long_src;
      end else begin
        case (st_q)
          ST_RUN: begin
            if (!rst_pin_in_i) begin
              st_q <= ST_PIN;
              pin_cnt_q <= 7'h00;
              internal_reset_o <= 1'b1;
            end else if (stop_exec_i) begin
              st_q <= ST_STOP;
              bus_clk_en_o <= 1'b0;
            end
          end
          ST_LONG: begin
            if (osc_ref_tick_i) begin
              if (cnt_q == `RSQ_POR_CYC - 1) begin
                cnt_q <= 13'h0000;
                st_q <= ST_DRIVE;
                bus_clk_en_o <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 13'h0001;
              end
            end
          end
          ST_DRIVE: begin
            if (osc_ref_tick_i) begin
              if (cnt_q == `RSQ_PIN_DRIVE_CYC - 1) begin
                cnt_q <= 13'h0000;
                st_q <= ST_HOLD;
                rst_pin_oe_o <= 1'b0;
              end else begin
                cnt_q <= cnt_q + 13'h0001;
              end
            end
          end
          ST_HOLD: begin
            if (osc_ref_tick_i) begin
              if (cnt_q == `RSQ_INTERNAL_RESET_SIGNAL_EXTRA_CYC - 1) begin
                cnt_q <= 13'h0000;
                st_q <= ST_RUN;
                internal_reset_o <= 1'b0;
              end else begin
                cnt_q <= cnt_q + 13'h0001;
              end
            end
          end
          ST_PIN: begin
            // pin flag after 67 cycles low
            if (rst_pin_in_i) begin
              st_q <= ST_RUN;
              internal_reset_o <= 1'b0;
            end else if (osc_ref_tick_i && pin_cnt_q != 7'h7f) begin
              pin_cnt_q <= pin_cnt_q + 7'h01;
              if (pin_cnt_q == `RSQ_PIN_MIN_CYC - 1) begin
                cause_q <= 8'h01 << `RSQ_CAUSE_PIN;
              end
            end
          end
          ST_STOP: begin
            if (wake_i) begin
              st_q <= ST_WAKE;
            end
          end
          ST_WAKE: begin
            if (osc_ref_tick_i && pre_q == (option_q[`RSQ_OPT_SHORT_REC] ?
                `RSQ_REC_SHORT_CYC - 1 : `RSQ_REC_LONG_CYC - 1)) begin
              st_q <= ST_RUN;
              bus_clk_en_o <= 1'b1;
            end
          end
          ST_TAIL: begin
            st_q <= ST_RUN;
          end
          default: begin
            st_q <= ST_RUN;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Prescaler and watchdog
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= 13'h0000;
      wdog_q <= 8'h00;
      wd_s1_q <= 1'b0;
      wd_s2_q <= 1'b0;
    end else begin
      wd_s1_q <= wdog_async_i | ((&wdog_q) & pre_ovf & ~wdog_disable);
      wd_s2_q <= wd_s1_q;
      if (int_src || stop_exec_i) begin
        // clear on internal reset or stop
        pre_q <= 13'h0000;
        wdog_q <= 8'h00;
      end else if (top_vec_wr_i) begin
        pre_q <= {9'h000, pre_q[3:0]};
        wdog_q <= 8'h00;
      end else if (osc_ref_tick_i && st_q != ST_STOP) begin
        pre_q <= pre_q + 13'h0001;
        if (pre_ovf && !wdog_disable && !internal_reset_o) begin
          wdog_q <= wdog_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt control
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_lat_q <= 8'h00;
      irq_held_q <= 1'b0;
      held_vec_q <= 3'd0;
      irq_take_o <= 1'b0;
      irq_vec_o <= 3'd0;
      irq_mask_o <= 1'b1;
      stack_save_o <= 1'b0;
      stack_restore_o <= 1'b0;
    end else begin
      irq_take_o <= 1'b0;
      stack_save_o <= 1'b0;
      stack_restore_o <= 1'b0;
      irq_lat_q <= irq_lat_q | irq_req_i;
      if (reg_wr_i && reg_addr_i == `RSQ_REG_STATUS && reg_wdata_i[0]) begin
        irq_mask_o <= 1'b0;
      end
      if (internal_reset_o) begin
        irq_lat_q <= 8'h00;
        irq_held_q <= 1'b0;
        irq_mask_o <= 1'b1;
      end else if (rti_i) begin
        stack_restore_o <= 1'b1;
        irq_mask_o <= 1'b0;
      end else if (irq_held_q) begin
        // held until serviced or mask set
        if (irq_mask_o) begin
          irq_held_q <= 1'b0;
        end else if (instr_done_i) begin
          irq_take_o <= 1'b1;
          irq_vec_o <= held_vec_q;
          stack_save_o <= 1'b1;
          irq_mask_o <= 1'b1;
          irq_held_q <= 1'b0;
          irq_lat_q <= (irq_lat_q & ~(8'h01 << held_vec_q)) | irq_req_i;
        end
      end else if (!irq_mask_o && |live) begin
        irq_held_q <= 1'b1;
        held_vec_q <= prio(live);
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      option_q <= `RSQ_OPT_RST;
      irq_en_q <= 8'h00;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `RSQ_REG_OPTION) begin
        option_q <= reg_wdata_i & 8'h03;
      end
      if (reg_wr_i && reg_addr_i == `RSQ_REG_IRQ_EN) begin
        irq_en_q <= reg_wdata_i;
      end
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RSQ_REG_CAUSE: reg_rdata_o <= cause_q;
          `RSQ_REG_OPTION: reg_rdata_o <= option_q;
          `RSQ_REG_IRQ_EN: reg_rdata_o <= irq_en_q;
          `RSQ_REG_IRQ_PEND: reg_rdata_o <= irq_lat_q;
          `RSQ_REG_STATUS: reg_rdata_o <= {internal_reset_o, st_q, 3'b000, irq_mask_o};
          `RSQ_REG_IRQ_VEC: reg_rdata_o <= {irq_held_q, 4'h0, held_vec_q};
          `RSQ_REG_PRESCALE: reg_rdata_o <= pre_q[12:5];
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

/* rsq_props.sv */
module rsq_props (
  input wire sys_clk_i, // Clock
  input wire rst_b_i, // Reset, active low
  input wire osc_ref_tick_i, // Reference tick
  input wire wdog_async_i, // Watchdog request
  input wire bad_opcode_i, // Illegal opcode
  input wire opcode_fetch_i, // Opcode fetch
  input wire unmapped_i, // Unmapped access
  input wire instr_done_i, // Instruction end
  input wire rti_i, // Return from interrupt
  input wire rst_pin_oe_o, // Pin drive
  input wire internal_reset_o, // Internal reset
  input wire irq_take_o, // Interrupt entry
  input wire irq_mask_o, // Mask bit
  input wire stack_save_o, // Stack save
  input wire stack_restore_o // Stack restore
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] hold_cnt_q;
  logic armed_q;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----
  // Ticks from end of pin drive to release
  // ----
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt_q <= 6'h00;
      armed_q <= 1'b0;
    end else if (rst_pin_oe_o) begin
      hold_cnt_q <= 6'h00;
      armed_q <= 1'b1;
    end else begin
      if (!internal_reset_o) armed_q <= 1'b0;
      if (osc_ref_tick_i && internal_reset_o && hold_cnt_q != 6'h3f) hold_cnt_q <= hold_cnt_q + 6'h01;
    end
  end
  chk_internal_reset_signal_hold: assert property ($fell(internal_reset_o) && armed_q |-> hold_cnt_q == 6'h20)
    else $error("internal reset hold length wrong");
  chk_oe_inside: assert property (rst_pin_oe_o |-> internal_reset_o)
    else $error("pin driven without internal reset");
  chk_src_opcode: assert property (bad_opcode_i && !internal_reset_o |=> rst_pin_oe_o && internal_reset_o)
    else $error("illegal opcode gave no reset");
  chk_fetch_bad: assert property (opcode_fetch_i && unmapped_i && !internal_reset_o |=> internal_reset_o)
    else $error("bad fetch gave no reset");
  chk_wdog_sync: assert property ($rose(wdog_async_i) && !internal_reset_o |-> ##[1:5] rst_pin_oe_o)
    else $error("watchdog request gave no reset");
  chk_take_gate: assert property (irq_take_o |-> $past(instr_done_i) && !$past(irq_mask_o))
    else $error("interrupt entry off boundary or masked");
  chk_take_save: assert property (irq_take_o |-> stack_save_o ##1 irq_mask_o)
    else $error("entry without save or mask");
  chk_rti_restore: assert property (stack_restore_o |-> $past(rti_i) ##1 !irq_mask_o)
    else $error("restore without return or mask left set");
  cover property (irq_take_o);
  cover property ($fell(internal_reset_o) && armed_q);
  cover property (stack_restore_o);
endmodule

/* rsq_far_model.sv */
module rsq_far_model #(
  parameter int TICK_DIV = 2
) (
  input wire logic sys_clk_i, // System clock
  input wire logic pin_oe_i, // Device drives reset line
  input wire logic pin_out_i, // Device drive level
  input wire logic ext_low_i, // Other chip pulls line low
  output wire logic ref_tick_o, // Reference clock falling edge
  output wire logic pin_level_o // Resolved reset line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_q = 4'h0;
  // Free-running oscillator, one tick per TICK_DIV cycles
  always @(posedge sys_clk_i) begin
    div_q <= (div_q == 4'(TICK_DIV - 1)) ? 4'h0 : div_q + 4'h1;
  end
  assign ref_tick_o = (div_q == 4'h0);
  // line pulled up, low when any party drives it
  assign pin_level_o = !((pin_oe_i && !pin_out_i) || ext_low_i);
endmodule

/* rsq_reset_sequencer_tb_top.sv */
`include "rsq_defs.vh"
module rsq_reset_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wdog = 1'b0;
  logic ext_low = 1'b0;
  logic rd_pend = 1'b0;
  logic wake = 1'b0;
  logic [1:0] mon = 2'b00;
  logic [1:0] fetch = 2'b00;
  logic [6:0] pv = 7'h00;
  logic [7:0] irq_req = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] lfsr = 32'h83f5_fe98;
  logic [7:0] exp_rd[$];
  logic [2:0] exp_vec[$];
  logic [7:0] short_cause[4] = '{8'h10, 8'h10, 8'h08, 8'h20};
  int fail_count = 0;
  int cmp_count = 0;
  wire tick, pin_level, oe, pin_out, internal_reset_signal, clk_en, take, mask, save, restore;
  wire [7:0] rdata;
  wire [2:0] vec;
  always #50 sys_clk_i = ~sys_clk_i;
  rsq_far_model rsq_far_model_inst (.sys_clk_i(sys_clk_i), .pin_oe_i(oe), .pin_out_i(pin_out),
    .ext_low_i(ext_low), .ref_tick_o(tick), .pin_level_o(pin_level));
  rsq_reset_sequencer rsq_reset_sequencer_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .osc_ref_tick_i(tick), .power_on_pulse_i(pv[0]), .low_voltage_i(pv[1]),
    .wdog_async_i(wdog), .bad_opcode_i(pv[2]), .stop_exec_i(pv[3]), .opcode_fetch_i(fetch[1]),
    .unmapped_i(fetch[0]), .top_vec_wr_i(pv[4]), .monitor_mode_i(mon[0]), .break_state_i(1'b0),
    .hv_rst_pin_i(1'b0), .hv_irq_pin_i(mon[1]), .wake_i(wake), .rst_pin_in_i(pin_level),
    .irq_req_i(irq_req), .instr_done_i(pv[6]), .rti_i(pv[5]), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .rst_pin_out_o(pin_out), .rst_pin_oe_o(oe), .internal_reset_o(internal_reset_signal), .bus_clk_en_o(clk_en),
    .irq_take_o(take), .irq_vec_o(vec), .irq_mask_o(mask), .stack_save_o(save),
    .stack_restore_o(restore));
  // ----
  // Helpers
  // ----
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic pls(input int b);
    pv[b] <= 1'b1;
    @(posedge sys_clk_i);
    pv[b] <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk_i);
    wr_s <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic seq_chk(input int oe_t, input logic [7:0] cause, input bit lng);
    int n;
    int t;
    int bt;
    n = 0;
    t = 0;
    bt = 0;
    while (!oe && n < 20) begin
      @(posedge sys_clk_i);
      n++;
    end
    bound(n, 20);
    while (oe && n < 20000) begin
      if (lng && clk_en && bt == 0) bt = t;
      t += tick;
      @(posedge sys_clk_i);
      n++;
    end
    chk("pin drive ticks", oe_t, t);
    if (lng) chk("clock start ticks", 4096, bt);
    t = 0;
    while (internal_reset_signal && n < 20000) begin
      t += tick;
      @(posedge sys_clk_i);
      n++;
    end
    bound(n, 20000);
    chk("internal hold ticks", 32, t);
    chk("bus clocks on", 1, clk_en);
    rd(`RSQ_REG_CAUSE, cause);
    $display("test reset sequence cause %h finished", cause);
  endtask
  // ----
  // Result watcher
  // ----
  always @(posedge sys_clk_i) begin
    if (rd_pend) chk("read data", exp_rd.size() ? exp_rd.pop_front() : 8'hxx, rdata);
    rd_pend <= rd_s;
    if (take) chk("irq vector", exp_vec.size() ? exp_vec.pop_front() : 3'bxxx, vec);
  end
  initial begin
    #(100 * 60000);
    fail_count++;
    report_and_stop();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    int n;
    int t;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    seq_chk(4128, `RSQ_CAUSE_RST, 1);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) begin
        pls(k + 2);
      end else if (k == 2) begin
        fetch <= 2'b11;
        @(posedge sys_clk_i);
        fetch <= 2'b00;
      end else begin
        fork
          begin
            #37 wdog = 1'b1;
            #100 wdog = 1'b0;
          end
        join_none
      end
      seq_chk(32, short_cause[k], 0);
    end
    fetch <= 2'b01;
    @(posedge sys_clk_i);
    fetch <= 2'b00;
    repeat (10) @(posedge sys_clk_i);
    chk("data access reset", 0, internal_reset_signal);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    wr(4'hf, lfsr[7:0]);
    rd(4'hf, 8'h00);
    rd(`RSQ_REG_CAUSE, 8'h20);
    $display("test data access finished");
    ext_low <= 1'b1;
    repeat (150) @(posedge sys_clk_i);
    ext_low <= 1'b0;
    n = 0;
    while (internal_reset_signal && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    bound(n, 200);
    rd(`RSQ_REG_CAUSE, 8'h40);
    repeat (300) @(posedge sys_clk_i);
    pls(4);
    rd(`RSQ_REG_PRESCALE, 8'h00);
    $display("test pin reset and service finished");
    wr(`RSQ_REG_IRQ_EN, 8'hff);
    wr(`RSQ_REG_STATUS, 8'h01);
    irq_req <= 8'h28;
    repeat (2) @(posedge sys_clk_i);
    irq_req <= 8'h20;
    @(posedge sys_clk_i);
    exp_vec.push_back(3'h3);
    pls(6);
    repeat (2) @(posedge sys_clk_i);
    chk("mask after entry", 1, mask);
    pls(6);
    repeat (2) @(posedge sys_clk_i);
    pls(5);
    repeat (2) @(posedge sys_clk_i);
    chk("mask after return", 0, mask);
    exp_vec.push_back(3'h5);
    pls(6);
    irq_req <= 8'h00;
    repeat (3) @(posedge sys_clk_i);
    chk("vectors left", 0, exp_vec.size());
    $display("test interrupts finished");
    wr(`RSQ_REG_OPTION, 8'h03);
    mon <= 2'b11;
    pls(3);
    repeat (5) @(posedge sys_clk_i);
    chk("bus clocks in stop", 0, clk_en);
    wake <= 1'b1;
    @(posedge sys_clk_i);
    wake <= 1'b0;
    @(posedge sys_clk_i);
    n = 0;
    t = 0;
    while (!clk_en && n < 10000) begin
      t += tick;
      @(posedge sys_clk_i);
      n++;
    end
    bound(n, 10000);
    chk("stop recovery ticks", `RSQ_REC_SHORT_CYC, t);
    chk("reset in stop", 0, internal_reset_signal);
    mon <= 2'b00;
    $display("test stop recovery finished");
    for (int k = 0; k < 2; k++) begin
      pls(1 - k);
      seq_chk(4128, k ? 8'h80 : 8'h02, 1);
    end
    repeat (2) @(posedge sys_clk_i);
    chk("reads left", 0, exp_rd.size());
    report_and_stop();
  end
endmodule
bind rsq_reset_sequencer rsq_props rsq_props_inst (.sys_clk_i, .rst_b_i, .osc_ref_tick_i,
  .wdog_async_i, .bad_opcode_i, .opcode_fetch_i, .unmapped_i, .instr_done_i, .rti_i,
  .rst_pin_oe_o, .internal_reset_o, .irq_take_o, .irq_mask_o, .stack_save_o, .stack_restore_o);
